/* File: src/mmp_pkg.sv */
// Purpose: Shared types and constants for the move, multiply, OR and stack-restore execution block.
// Assumes: Sixteen register entries, each held as 32 bits; narrow registers use the low half.
// Notes:   Operand size tells the source width of extending moves and the data width of all others.
package mmp_pkg;
    typedef enum logic [3:0] {
        op_nop                    = 4'h0,
        op_move                   = 4'h1,
        op_sign_extend_move       = 4'h2,
        op_zero_extend_move       = 4'h3,
        op_same_size_multiply     = 4'h4,
        op_signed_byte_multiply   = 4'h5,
        op_signed_word_multiply   = 4'h6,
        op_unsigned_word_multiply = 4'h7,
        op_bitwise_or             = 4'h8,
        op_stack_restore          = 4'h9
    } mmp_op_type;

    typedef enum logic [1:0] {
        size_byte  = 2'h0,
        size_word  = 2'h1,
        size_dword = 2'h2
    } mmp_size_type;

    typedef enum logic [0:0] {
        st_idle    = 1'h0,
        st_restore = 1'h1
    } mmp_state_type;

    localparam int         REG_COUNT      = 16;
    localparam logic [3:0] RA_INDEX       = 4'hE;
    localparam logic [3:0] SP_INDEX       = 4'hF;
    localparam logic [3:0] WIDE_FIRST     = 4'hC;
    localparam logic [3:0] RA_WORDS       = 4'h2;
    localparam logic [3:0] MAX_COUNT      = 4'h8;
    localparam logic [31:0] WORD_BYTES    = 32'h2;
    localparam logic [31:0] REG_RESET     = 32'h0;
endpackage : mmp_pkg

/* File: src/mmp_links.sv */
// Purpose: Carriers between the execution top and its arithmetic and stack-read helpers.
// Assumes: All signals live in the core clock domain.
// Notes:   The stack link start is a one-cycle pulse; word_valid is a one-cycle pulse per word.
`timescale 1ns/1ps
interface mmp_alu_if;
    import mmp_pkg::*;
    mmp_op_type   op;
    mmp_size_type size;
    logic [31:0]  src;
    logic [31:0]  dst;
    logic [31:0]  res;
    mmp_size_type wsize;
    logic         wen;
    modport exec (output op, size, src, dst, input res, wsize, wen);
    modport alu  (input op, size, src, dst, output res, wsize, wen);
endinterface : mmp_alu_if

interface mmp_stack_if;
    logic        start;
    logic [31:0] base;
    logic [3:0]  total;
    logic        word_valid;
    logic        word_last;
    logic [15:0] word_data;
    modport exec   (output start, base, total, input word_valid, word_last, word_data);
    modport reader (input start, base, total, output word_valid, word_last, word_data);
endinterface : mmp_stack_if

/* File: src/mmp_alu.sv */
// Purpose: Combinational result for moves, extensions, multiplies and OR.
// Assumes: Operands arrive already fetched; the caller decides where the result lands.
// Notes:   Write size may differ from operand size for extending and widening multiplies.
`timescale 1ns/1ps
module mmp_alu (
    // Operands and result.
    mmp_alu_if.alu port
);
    import mmp_pkg::*;

    logic signed [15:0] prod_sb;
    logic signed [31:0] prod_sw;
    logic        [31:0] prod_uw;

    always_comb begin
        prod_sb = $signed({{8{port.src[7]}}, port.src[7:0]}) * $signed({{8{port.dst[7]}}, port.dst[7:0]});
        prod_sw = $signed({{16{port.src[15]}}, port.src[15:0]}) * $signed({{16{port.dst[15]}}, port.dst[15:0]});
        prod_uw = {16'h0, port.src[15:0]} * {16'h0, port.dst[15:0]};
        port.res   = 32'h0;
        port.wsize = port.size;
        port.wen   = 1'b1;
        case (port.op)
            op_move: begin
                port.res = port.src;
            end
            op_sign_extend_move: begin
                if (port.size == size_byte) begin
                    port.res   = {{24{port.src[7]}}, port.src[7:0]};
                    port.wsize = size_word;
                end else begin
                    port.res   = {{16{port.src[15]}}, port.src[15:0]};
                    port.wsize = size_dword;
                end
            end
            op_zero_extend_move: begin
                if (port.size == size_byte) begin
                    port.res   = {24'h0, port.src[7:0]};
                    port.wsize = size_word;
                end else begin
                    port.res   = {16'h0, port.src[15:0]};
                    port.wsize = size_dword;
                end
            end
            op_same_size_multiply: begin
                port.res = (port.size == size_byte) ? {16'h0, prod_sb} : prod_sw;
            end
            op_signed_byte_multiply: begin
                port.res   = {16'h0, prod_sb};
                port.wsize = size_word;
            end
            op_signed_word_multiply: begin
                port.res   = prod_sw;
                port.wsize = size_dword;
            end
            op_unsigned_word_multiply: begin
                port.res   = prod_uw;
                port.wsize = size_dword;
            end
            op_bitwise_or: begin
                port.res = port.src | port.dst;
            end
            default: begin
                port.wen = 1'b0;
            end
        endcase
    end
endmodule : mmp_alu

/* File: src/mmp_stack_reader.sv */
// Purpose: Reads consecutive stack words upward from a base address, one request at a time.
// Assumes: The stack memory answers a held request with a one-cycle acknowledge carrying data.
// Notes:   Only reads are issued; popped locations are never written.
`timescale 1ns/1ps
module mmp_stack_reader (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Link to the execution top.
    mmp_stack_if.reader      lnk,
    // Stack memory read port.
    output logic             stk_rd_req,
    output logic [31:0]      stk_addr,
    input  wire logic        stk_ack,
    input  wire logic [15:0] stk_rd_data
);
    import mmp_pkg::*;

    logic [3:0] left;
    logic       active;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stk_addr <= 32'h0;
            left     <= 4'h0;
            active   <= 1'b0;
        end else if (lnk.start) begin
            stk_addr <= lnk.base;
            left     <= lnk.total;
            active   <= (lnk.total != 4'h0);
        end else if (active && stk_ack) begin
            stk_addr <= stk_addr + WORD_BYTES;
            left     <= left - 4'h1;
            active   <= (left != 4'h1);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lnk.word_valid <= 1'b0;
            lnk.word_last  <= 1'b0;
            lnk.word_data  <= 16'h0;
        end else begin
            lnk.word_valid <= active && stk_ack;
            lnk.word_last  <= active && stk_ack && (left == 4'h1);
            lnk.word_data  <= stk_rd_data;
        end
    end

    assign stk_rd_req = active;
endmodule : mmp_stack_reader

/* File: src/mmp_exec.sv */
// Purpose: Executes moves, extensions, multiplies, OR, no-operation and the stack restore.
// Assumes: Decode presents one operation with valid/ready; the stack memory is on the same clock.
// Notes:   Status flags and traps are never touched by this group.
//
// Summary of operation
// - Moves copy register or immediate source unchanged; byte, word, double word.
// - Sign-extending moves fill every added high bit with the source sign.
// - Zero-extending moves fill every added high bit with zero.
// - Same-size multiply is signed, writes destination, drops bits beyond its width.
// - Signed byte multiply writes the full signed 16-bit product.
// - Signed word multiply writes the full signed 32-bit product to a pair.
// - Unsigned word multiply writes the full unsigned 32-bit product to a pair.
// - No-operation changes no state and just moves to the next instruction.
// - OR combines source and destination bitwise at any size into destination.
// - Byte operations on a 16-bit register keep its high byte.
// - Stack restore reloads 1 to 8 words into consecutive registers from the start one.
// - First register takes the lowest address, return address the highest; pointer grows.
// - A double-word register uses two words of the count and two stack words.
// - The stack restore is atomic; no interrupt between its loads.
// - Return variant jumps to the return address afterwards; plain one continues.
// - Three operands restore registers and return address, two registers, one address.
// - Return address is one register whether the short bit is clear or set; both words go into it.
// - The stack restore only reads popped words and never writes them.
`timescale 1ns/1ps
module mmp_exec (
    // Clock and reset.
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // Configuration.
    input  wire logic                 short_register_config_bit,
    // Operation from decode.
    input  wire logic                 op_valid,
    output logic                      op_ready,
    input  wire mmp_pkg::mmp_op_type   op_code,
    input  wire mmp_pkg::mmp_size_type op_size,
    input  wire logic [3:0]           src_sel,
    input  wire logic [3:0]           dst_sel,
    input  wire logic                 use_imm,
    input  wire logic [31:0]          imm_value,
    input  wire logic [3:0]           pop_count,
    input  wire logic                 pop_with_regs,
    input  wire logic                 pop_with_ra,
    input  wire logic                 pop_ret,
    // Completion and control flow.
    output logic                      done,
    output logic                      seq_advance,
    output logic                      jump_valid,
    output logic [31:0]               jump_addr,
    output logic                      int_block,
    output logic                      flags_we,
    output logic                      trap_req,
    // Register observation.
    input  wire logic [3:0]           rd_sel,
    output logic [31:0]               rd_data,
    // Stack memory read port.
    output logic                      stk_rd_req,
    output logic [31:0]               stk_addr,
    input  wire logic                 stk_ack,
    input  wire logic [15:0]          stk_rd_data
);
    import mmp_pkg::*;

    mmp_alu_if     alu_bus ();
    mmp_stack_if   stk_lnk ();
    mmp_state_type state;
    logic [31:0]   gpr [REG_COUNT];
    logic          accept;
    logic          pop_begin;
    logic [3:0]    pop_total;
    logic [3:0]    src_hi;
    logic [3:0]    dst_hi;
    logic [31:0]   src_val;
    logic [31:0]   dst_val;
    logic [3:0]    cur_idx;
    logic          cur_half;
    logic [3:0]    regs_left;
    logic          ra_half;
    logic          ret_pending;
    logic          ra_pending;
    logic [31:0]   sp_expect;
    logic [31:0]   next_sp;
    logic [31:0]   ra_final;
    logic          pop_end;

    function automatic logic is_wide(input logic [3:0] idx, input logic sr);
        return !sr && (idx >= WIDE_FIRST);
    endfunction : is_wide

    mmp_alu u_alu (
        .port (alu_bus)
    );

    mmp_stack_reader u_reader (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .lnk         (stk_lnk),
        .stk_rd_req  (stk_rd_req),
        .stk_addr    (stk_addr),
        .stk_ack     (stk_ack),
        .stk_rd_data (stk_rd_data)
    );

    assign op_ready  = (state == st_idle);
    assign accept    = op_valid && op_ready;
    assign src_hi    = 4'(src_sel + 4'h1);
    assign dst_hi    = 4'(dst_sel + 4'h1);
    assign pop_total = 4'((pop_with_regs ? pop_count : 4'h0) + (pop_with_ra ? RA_WORDS : 4'h0));
    assign pop_begin = accept && (op_code == op_stack_restore) && (pop_total != 4'h0);
    assign pop_end   = stk_lnk.word_valid && stk_lnk.word_last;
    assign next_sp   = sp_expect;
    // return address assembled from two words
    assign ra_final  = ra_pending ? {stk_lnk.word_data, gpr[RA_INDEX][15:0]} : gpr[RA_INDEX];

    assign flags_we  = 1'b0;
    assign trap_req  = 1'b0;

    always_comb begin
        if (use_imm) begin
            src_val = imm_value;
        end else if (op_size == size_dword && !is_wide(src_sel, short_register_config_bit)) begin
            src_val = {gpr[src_hi][15:0], gpr[src_sel][15:0]};
        end else begin
            src_val = gpr[src_sel];
        end
        if (op_size == size_dword && !is_wide(dst_sel, short_register_config_bit)) begin
            dst_val = {gpr[dst_hi][15:0], gpr[dst_sel][15:0]};
        end else begin
            dst_val = gpr[dst_sel];
        end
    end

    assign alu_bus.op   = op_code;
    assign alu_bus.size = op_size;
    assign alu_bus.src  = src_val;
    assign alu_bus.dst  = dst_val;
    assign stk_lnk.start = pop_begin;
    assign stk_lnk.base  = gpr[SP_INDEX];
    assign stk_lnk.total = pop_total;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= st_idle;
        end else if (pop_begin) begin
            state <= st_restore;
        end else if (pop_end) begin
            state <= st_idle;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                gpr[i] <= REG_RESET;
            end
        end else begin
            if (accept && alu_bus.wen) begin
                case (alu_bus.wsize)
                    size_byte: begin
                        gpr[dst_sel][7:0] <= alu_bus.res[7:0];
                    end
                    size_word: begin
                        gpr[dst_sel][15:0] <= alu_bus.res[15:0];
                    end
                    default: begin
                        if (is_wide(dst_sel, short_register_config_bit)) begin
                            gpr[dst_sel] <= alu_bus.res;
                        end else begin
                            gpr[dst_sel][15:0] <= alu_bus.res[15:0];
                            gpr[dst_hi][15:0]  <= alu_bus.res[31:16];
                        end
                    end
                endcase
            end
            if (stk_lnk.word_valid) begin
                if (regs_left != 4'h0) begin
                    if (cur_half) begin
                        gpr[cur_idx][31:16] <= stk_lnk.word_data;
                    end else begin
                        gpr[cur_idx][15:0] <= stk_lnk.word_data;
                    end
                end else if (ra_half) begin
                    gpr[RA_INDEX][31:16] <= stk_lnk.word_data;
                end else begin
                    gpr[RA_INDEX][15:0] <= stk_lnk.word_data;
                end
            end
            if (pop_end) begin
                gpr[SP_INDEX] <= next_sp;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_idx     <= 4'h0;
            cur_half    <= 1'b0;
            regs_left   <= 4'h0;
            ra_half     <= 1'b0;
            ret_pending <= 1'b0;
            ra_pending  <= 1'b0;
            sp_expect   <= 32'h0;
        end else if (pop_begin) begin
            cur_idx     <= src_sel;
            cur_half    <= 1'b0;
            regs_left   <= pop_with_regs ? pop_count : 4'h0;
            ra_half     <= 1'b0;
            ret_pending <= pop_ret;
            ra_pending  <= pop_with_ra;
            sp_expect   <= gpr[SP_INDEX] + {27'h0, pop_total, 1'b0};
        end else if (stk_lnk.word_valid) begin
            if (regs_left != 4'h0) begin
                regs_left <= regs_left - 4'h1;
                if (is_wide(cur_idx, short_register_config_bit) && !cur_half) begin
                    cur_half <= 1'b1;
                end else begin
                    cur_idx  <= 4'(cur_idx + 4'h1);
                    cur_half <= 1'b0;
                end
            end else begin
                ra_half <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            done        <= 1'b0;
            seq_advance <= 1'b0;
            jump_valid  <= 1'b0;
            jump_addr   <= 32'h0;
            rd_data     <= 32'h0;
        end else begin
            done        <= (accept && !pop_begin) || pop_end;
            seq_advance <= (accept && !pop_begin && !(op_code == op_stack_restore && pop_ret))
                           || (pop_end && !ret_pending);
            jump_valid  <= pop_end && ret_pending;
            if (pop_end && ret_pending) begin
                jump_addr <= {ra_final[30:0], 1'b0};
            end
            rd_data     <= gpr[rd_sel];
        end
    end

    assign int_block = (state == st_restore);

    // Checking helpers.
    logic [15:0] chk_mul_w;
    logic [15:0] chk_sb;
    logic [31:0] chk_sw;
    logic [31:0] chk_uw;
    logic        chk_byte_op;
    assign chk_mul_w   = src_val[15:0] * dst_val[15:0];
    assign chk_sb      = {{8{src_val[7]}}, src_val[7:0]} * {{8{dst_val[7]}}, dst_val[7:0]};
    assign chk_sw      = {{16{src_val[15]}}, src_val[15:0]} * {{16{dst_val[15]}}, dst_val[15:0]};
    assign chk_uw      = {16'h0, src_val[15:0]} * {16'h0, dst_val[15:0]};
    assign chk_byte_op = accept && op_size == size_byte
                         && (op_code == op_move || op_code == op_bitwise_or || op_code == op_same_size_multiply);

    default clocking chk_clk @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence pop_starts;
        pop_begin;
    endsequence
    sequence pop_finishes;
        $fell(int_block) && done;
    endsequence

    mov_copy_a: assert property (accept && op_code == op_move && op_size == size_word
        |=> gpr[$past(dst_sel)][15:0] == $past(src_val[15:0]))
        else $error("word move did not copy source");
    sext_fill_a: assert property (accept && op_code == op_sign_extend_move && op_size == size_byte
        |=> gpr[$past(dst_sel)][15:0] == {{8{$past(src_val[7])}}, $past(src_val[7:0])})
        else $error("sign extension wrong");
    zext_fill_a: assert property (accept && op_code == op_zero_extend_move && op_size == size_byte
        |=> gpr[$past(dst_sel)][15:8] == 8'h00)
        else $error("zero extension left high bits set");
    mul_trunc_a: assert property (accept && op_code == op_same_size_multiply && op_size == size_word
        |=> gpr[$past(dst_sel)][15:0] == $past(chk_mul_w))
        else $error("same size product not truncated");
    mulsb_full_a: assert property (accept && op_code == op_signed_byte_multiply
        |=> gpr[$past(dst_sel)][15:0] == $past(chk_sb))
        else $error("signed byte product wrong");
    mulsw_pair_a: assert property (accept && op_code == op_signed_word_multiply
        |-> alu_bus.res == chk_sw && alu_bus.wsize == size_dword)
        else $error("signed word product wrong");
    muluw_pair_a: assert property (accept && op_code == op_unsigned_word_multiply
        |-> alu_bus.res == chk_uw && alu_bus.wsize == size_dword)
        else $error("unsigned word product wrong");
    nop_still_a: assert property (accept && op_code == op_nop
        |=> $stable(gpr[SP_INDEX]) && $stable(gpr[RA_INDEX]) && done && seq_advance)
        else $error("no-operation changed state");
    or_result_a: assert property (accept && op_code == op_bitwise_or && op_size == size_word
        |=> gpr[$past(dst_sel)][15:0] == $past(src_val[15:0] | dst_val[15:0]))
        else $error("OR result wrong");
    byte_keep_a: assert property (chk_byte_op && !is_wide(dst_sel, short_register_config_bit)
        |=> gpr[$past(dst_sel)][15:8] == $past(dst_val[15:8]))
        else $error("byte write disturbed high byte");
    count_load_a: assert property (pop_starts ##0 pop_with_regs
        |=> regs_left == $past(pop_count) && cur_idx == $past(src_sel))
        else $error("restore count not loaded");
    sp_grow_a: assert property (pop_finishes
        |-> gpr[SP_INDEX] == $past(sp_expect) && !stk_rd_req)
        else $error("stack pointer not advanced by popped size");
    wide_two_a: assert property (stk_lnk.word_valid && regs_left != 4'h0 && !cur_half
        && is_wide(cur_idx, short_register_config_bit) |=> cur_idx == $past(cur_idx) && cur_half)
        else $error("wide register did not take two words");
    atomic_hold_a: assert property (pop_starts |=> int_block && !op_ready [*2])
        else $error("restore not atomic");
    ret_jump_a: assert property (jump_valid
        |-> jump_addr == {gpr[RA_INDEX][30:0], 1'b0} && done && !seq_advance)
        else $error("return jump target wrong");
    ra_last_a: assert property (pop_starts ##0 pop_with_ra ##1 (!pop_end) [*1]
        |-> ra_pending)
        else $error("return address restore not armed");
endmodule : mmp_exec

/* File: verification/mmp_stack_mem.sv */
// Purpose: Stack memory model that answers held reads after a random wait.
// Assumes: The word at byte address x holds x[15:0] ^ 16'h5A3C.
// Notes:   Data is scrambled outside the acknowledge cycle.
`timescale 1ns/1ps
module mmp_stack_mem (
    // Clock and read port.
    input  wire logic        core_clk,
    input  wire logic        stk_rd_req,
    input  wire logic [31:0] stk_addr,
    output logic             stk_ack = 0,
    output logic [15:0]      stk_rd_data = 0
);
    int seed = 32'h02657757;
    always @(posedge core_clk) begin
        stk_ack <= 0;
        stk_rd_data <= ~stk_rd_data;
        if (stk_rd_req && !stk_ack && $random(seed) % 2 == 0) begin
            stk_ack <= 1;
            stk_rd_data <= stk_addr[15:0] ^ 16'h5A3C;
        end
    end
endmodule : mmp_stack_mem

/* File: verification/test_move_multiply_or_pop_exec.sv */
// Purpose: Self-checking bench for the move, multiply, OR and stack-restore block.
// Assumes: Short-register bit low until the last scenarios, so entries 12 to 15 are wide.
// Notes:   Register reads are queued and checked by a watcher.
`timescale 1ns/1ps
module test_move_multiply_or_pop_exec;
    import mmp_pkg::*;
    typedef struct packed {
        mmp_op_type c;
        mmp_size_type z;
        logic [3:0] s, d;
        logic ui;
        logic [31:0] im;
        logic [3:0] pc;
        logic pr, pa, pt;
    } mmp_tb_cmd_type;
    mmp_tb_cmd_type k = '0;
    logic core_clk = 0, nrst = 0, op_valid = 0, want = 0, want_d = 0, sr = 0;
    logic op_ready, done, seq_advance, jump_valid, int_block, flags_we, trap_req, stk_rd_req, stk_ack;
    logic [3:0] rd_sel = 0;
    logic [15:0] a, b, stk_rd_data;
    logic [31:0] rd_data, jump_addr, stk_addr, w, m;
    logic [35:0] t, q[$];
    int seed = 32'h02657757, n_mismatch = 0, samples_checked = 0;
    mmp_exec DUT (.core_clk, .nrst, .short_register_config_bit(sr), .op_valid, .op_ready, .op_code(k.c),
        .op_size(k.z), .src_sel(k.s), .dst_sel(k.d), .use_imm(k.ui), .imm_value(k.im), .pop_count(k.pc),
        .pop_with_regs(k.pr), .pop_with_ra(k.pa), .pop_ret(k.pt), .done, .seq_advance, .jump_valid,
        .jump_addr, .int_block, .flags_we, .trap_req, .rd_sel, .rd_data, .stk_rd_req, .stk_addr, .stk_ack,
        .stk_rd_data);
    mmp_stack_mem stack (.core_clk, .stk_rd_req, .stk_addr, .stk_ack, .stk_rd_data);
    initial forever #4 core_clk = ~core_clk;
    function automatic logic [15:0] sw(logic [31:0] x);
        return x[15:0] ^ 16'h5A3C;
    endfunction : sw
    task automatic fail(string s, logic [31:0] e, v);
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", s, e, v);
    endtask : fail
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic run(mmp_tb_cmd_type x, logic j);
        int n;
        n = 0;
        @(negedge core_clk);
        k = x;
        op_valid = 1;
        @(negedge core_clk);
        op_valid = 0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        samples_checked++;
        if (n == 200 || {seq_advance, jump_valid} !== {~j, j}) fail("completion", {~j, j}, {seq_advance, jump_valid});
    endtask : run
    task automatic alu(mmp_op_type c, mmp_size_type z, logic [3:0] s, d, logic [31:0] im, logic ui = 1);
        run('{c, z, s, d, ui, im, 4'h0, 1'b0, 1'b0, 1'b0}, 1'b0);
    endtask : alu
    task automatic pop(logic [3:0] d, c, logic r, p, j);
        run('{op_stack_restore, size_word, d, 4'h0, 1'b0, 32'h0, c, r, p, j}, j);
    endtask : pop
    task automatic look(logic [3:0] s, logic [31:0] e);
        @(negedge core_clk);
        rd_sel = s;
        q.push_back({s, e});
        want = 1;
        @(negedge core_clk);
        want = 0;
    endtask : look
    always @(posedge core_clk) want_d <= want;
    always @(negedge core_clk) begin
        if (flags_we !== 0 || trap_req !== 0 || (stk_rd_req === 1 && (int_block !== 1 || op_ready !== 0))) fail("side", 0, 1);
        if (want_d) begin
            t = q.pop_front();
            m = (t[35:32] >= 12 && !sr) ? 32'hFFFFFFFF : 32'hFFFF;
            samples_checked++;
            if ((rd_data & m) !== (t[31:0] & m)) fail("register", t[31:0], rd_data);
        end
    end
    initial begin
        repeat (8) @(negedge core_clk);
        nrst = 1;
        {a, b} = $random(seed);
        alu(op_move, size_dword, 0, 12, {b, a});
        look(12, {b, a});
        alu(op_move, size_word, 0, 1, {b, a});
        alu(op_move, size_byte, 0, 1, 32'hC3);
        alu(op_bitwise_or, size_byte, 0, 1, 32'h0C);
        look(1, {a[15:8], 8'hCF});
        alu(op_move, size_word, 0, 2, 32'hBB);
        alu(op_sign_extend_move, size_byte, 2, 3, 0, 0);
        look(3, 16'hFFBB);
        alu(op_zero_extend_move, size_byte, 2, 1, 0, 0);
        look(1, 16'h00BB);
        alu(op_move, size_word, 0, 7, a);
        for (int i = 8; i < 12; i++) alu(op_move, size_word, 0, 4'(i), b);
        alu(op_same_size_multiply, size_word, 7, 9, 0, 0);
        w = a * b;
        look(9, w[15:0]);
        alu(op_signed_word_multiply, size_word, 7, 8, 0, 0);
        w = $signed(a) * $signed(b);
        look(8, w[15:0]);
        look(9, w[31:16]);
        alu(op_unsigned_word_multiply, size_word, 7, 10, 0, 0);
        w = a * b;
        look(10, w[15:0]);
        look(11, w[31:16]);
        alu(op_move, size_word, 0, 6, 32'h3A);
        alu(op_signed_byte_multiply, size_byte, 2, 6, 0, 0);
        look(6, 16'hF05E);
        alu(op_nop, size_word, 0, 7, 32'hFFFF);
        look(7, a);
        alu(op_move, size_dword, 0, 15, 32'h1000);
        pop(3, 3, 1, 1, 1);
        for (int i = 0; i < 3; i++) look(4'(3 + i), sw(32'h1000 + 2 * i));
        w = {sw(32'h1008), sw(32'h1006)};
        look(14, w);
        look(15, 32'h100A);
        samples_checked++;
        if (jump_addr !== {w[30:0], 1'b0}) fail("jump", {w[30:0], 1'b0}, jump_addr);
        pop(12, 2, 1, 0, 0);
        look(12, {sw(32'h100C), sw(32'h100A)});
        pop(0, 0, 0, 1, 0);
        look(14, {sw(32'h1010), sw(32'h100E)});
        look(15, 32'h1012);
        sr = 1;
        pop(10, 3, 1, 0, 0);
        look(12, sw(32'h1016));
        look(15, 32'h1018);
        pop(0, 0, 0, 1, 1);
        w = {sw(32'h101A), sw(32'h1018)};
        samples_checked++;
        if (jump_addr !== {w[30:0], 1'b0}) fail("jump", {w[30:0], 1'b0}, jump_addr);
        wrap_up();
    end
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
endmodule : test_move_multiply_or_pop_exec
